// *** logic/vtp_pattern_gen.v ***
// test pattern generator with avalon register access and indirect register window
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "vtp_regs.vh"
module vtp_pattern_gen #(
  parameter DIV = `VTP_DIV_DEFAULT
) (
  input wire I_SYS_CLK,
  input wire I_RESET_N,
  input wire I_CLK_EN,
  input wire [9:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [3:0] I_AVS_BYTEENABLE,
  output wire [31:0] O_AVS_READDATA,
  output wire O_AVS_WAITREQUEST,
  input wire I_EXT_PCLK,
  input wire I_EXT_DE,
  input wire I_EXT_HS,
  input wire I_EXT_VS,
  output wire O_PIX_STROBE,
  output wire [7:0] O_PIX_R,
  output wire [7:0] O_PIX_G,
  output wire [7:0] O_PIX_B,
  output wire O_PIX_DE,
  output wire O_PIX_HS,
  output wire O_PIX_VS,
  output wire O_PATTERN_ACTIVE
);
  reg [7:0] ctrl_ff;
  reg [6:0] cfg_ff;
  reg [7:0] iaddr_ff;
  reg [7:0] ind_ff [0:`VTP_IND_COUNT-1];
  reg ack_ff;
  reg [7:0] rdata_ff;
  reg [3:0] pclk_sync_ff;
  reg [2:0] de_sync_ff;
  reg [2:0] hs_sync_ff;
  reg [2:0] vs_sync_ff;
  reg [7:0] div_ff;
  reg [15:0] h_ff;
  reg [15:0] v_ff;
  reg [7:0] frame_ff;
  reg [3:0] pat_ff;
  reg [7:0] r_ff;
  reg [7:0] g_ff;
  reg [7:0] b_ff;
  reg de_ff;
  reg hs_ff;
  reg vs_ff;
  reg strobe_ff;
  integer i;

  wire req = I_AVS_READ | I_AVS_WRITE;
  wire [7:0] idx = I_AVS_ADDRESS[9:2];
  wire word_ok = (I_AVS_ADDRESS[1:0] == 2'h0);
  wire do_write = I_CLK_EN & I_AVS_WRITE & ack_ff & I_AVS_BYTEENABLE[0] & word_ok;
  wire ind_hit = (iaddr_ff < `VTP_IND_COUNT);
  wire [4:0] ind_sel = iaddr_ff[4:0];

  // one wait state: the word is read at the first edge and stands at the accepting edge
  assign O_AVS_WAITREQUEST = req & (~ack_ff | ~I_CLK_EN);
  assign O_AVS_READDATA = {24'h000000, rdata_ff};

  // handshake and read data capture
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (I_CLK_EN) begin
      ack_ff <= req & ~ack_ff;
      if (I_AVS_READ & ~ack_ff) begin
        if (!word_ok) begin
          rdata_ff <= 8'h00;
        end else if (idx == `VTP_IDX_CTRL) begin
          rdata_ff <= {ctrl_ff[7:4], 1'b0, ctrl_ff[2:0]};
        end else if (idx == `VTP_IDX_CFG) begin
          rdata_ff <= {1'b0, cfg_ff};
        end else if (idx == `VTP_IDX_IADDR) begin
          rdata_ff <= iaddr_ff;
        end else if (idx == `VTP_IDX_IDATA) begin
          rdata_ff <= ind_hit ? ind_ff[ind_sel] : 8'h00;
        end else begin
          rdata_ff <= 8'h00;
        end
      end
    end
  end

  // register writes; unmapped or unselected lanes are dropped
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      ctrl_ff <= `VTP_CTRL_RST;
      cfg_ff <= 7'h00;
      iaddr_ff <= `VTP_IADDR_RST;
      for (i = 0; i < `VTP_IND_COUNT; i = i + 1) begin
        ind_ff[i] <= 8'h00;
      end
      ind_ff[`VTP_IND_RED] <= 8'hFF;
      ind_ff[`VTP_IND_FTIME] <= 8'h3C;
      ind_ff[`VTP_IND_HTOT] <= 8'h20;
      ind_ff[`VTP_IND_HTOT+1] <= 8'h03;
      ind_ff[`VTP_IND_VTOT] <= 8'h0D;
      ind_ff[`VTP_IND_VTOT+1] <= 8'h02;
      ind_ff[`VTP_IND_HACT] <= 8'h80;
      ind_ff[`VTP_IND_HACT+1] <= 8'h02;
      ind_ff[`VTP_IND_VACT] <= 8'hE0;
      ind_ff[`VTP_IND_VACT+1] <= 8'h01;
      ind_ff[`VTP_IND_HSW] <= 8'h60;
      ind_ff[`VTP_IND_VSW] <= 8'h02;
      ind_ff[`VTP_IND_HBP] <= 8'h30;
      ind_ff[`VTP_IND_VBP] <= 8'h21;
      ind_ff[`VTP_IND_MASK] <= 8'hFF;
      ind_ff[`VTP_IND_MASK+1] <= 8'hFF;
    end else if (do_write) begin
      if (idx == `VTP_IDX_CTRL) begin
        ctrl_ff <= {I_AVS_WRITEDATA[7:4], 1'b0, I_AVS_WRITEDATA[2:0]};
      end else if (idx == `VTP_IDX_CFG) begin
        cfg_ff <= I_AVS_WRITEDATA[6:0];
      end else if (idx == `VTP_IDX_IADDR) begin
        iaddr_ff <= I_AVS_WRITEDATA[7:0];
      end else if (idx == `VTP_IDX_IDATA) begin
        if (ind_hit) begin
          ind_ff[ind_sel] <= I_AVS_WRITEDATA[7:0];
        end
      end
    end
  end

  // configuration views
  wire en = ctrl_ff[`VTP_CTRL_EN];
  wire tsel = cfg_ff[`VTP_CFG_TSEL];
  wire [15:0] h_tot = {ind_ff[`VTP_IND_HTOT+1], ind_ff[`VTP_IND_HTOT]};
  wire [15:0] v_tot = {ind_ff[`VTP_IND_VTOT+1], ind_ff[`VTP_IND_VTOT]};
  wire [15:0] h_act = {ind_ff[`VTP_IND_HACT+1], ind_ff[`VTP_IND_HACT]};
  wire [15:0] v_act = {ind_ff[`VTP_IND_VACT+1], ind_ff[`VTP_IND_VACT]};
  wire [15:0] pat_mask = {ind_ff[`VTP_IND_MASK+1], ind_ff[`VTP_IND_MASK]};
  wire [15:0] h_sw = {8'h00, ind_ff[`VTP_IND_HSW]};
  wire [15:0] v_sw = {8'h00, ind_ff[`VTP_IND_VSW]};
  wire [15:0] h_start = h_sw + {8'h00, ind_ff[`VTP_IND_HBP]};
  wire [15:0] v_start = v_sw + {8'h00, ind_ff[`VTP_IND_VBP]};

  // pin synchronisers; only the second stage onward is looked at
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      pclk_sync_ff <= 4'h0;
      de_sync_ff <= 3'h0;
      hs_sync_ff <= 3'h0;
      vs_sync_ff <= 3'h0;
    end else if (I_CLK_EN) begin
      pclk_sync_ff <= {pclk_sync_ff[2:0], I_EXT_PCLK};
      de_sync_ff <= {de_sync_ff[1:0], I_EXT_DE};
      hs_sync_ff <= {hs_sync_ff[1:0], I_EXT_HS};
      vs_sync_ff <= {vs_sync_ff[1:0], I_EXT_VS};
    end
  end
  wire pclk_rise = pclk_sync_ff[2] & ~pclk_sync_ff[3];
  wire ext_de = de_sync_ff[2];
  wire ext_vs_rise = vs_sync_ff[1] & ~vs_sync_ff[2];

  // internal divided clock as a tick; divider kept as enable to stay in one domain
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      div_ff <= 8'h00;
    end else if (I_CLK_EN) begin
      div_ff <= (div_ff >= DIV - 1) ? 8'h00 : div_ff + 8'h01;
    end
  end
  wire div_tick = (div_ff == 8'h00);

  // external timing always follows the pixel clock
  wire pix_tick = tsel ? (cfg_ff[`VTP_CFG_EXTCLK] ? pclk_rise : div_tick) : pclk_rise;

  // own timing window
  wire h_end = (h_ff >= h_tot - 16'h0001);
  wire v_end = (v_ff >= v_tot - 16'h0001);
  wire int_de = (h_ff >= h_start) & (h_ff < h_start + h_act) & (v_ff >= v_start) & (v_ff < v_start + v_act);
  wire [15:0] ax = tsel ? h_ff - h_start : h_ff;
  wire [15:0] ay = tsel ? v_ff - v_start : v_ff;
  wire cur_de = tsel ? int_de : ext_de;
  wire frame_end = tsel ? (pix_tick & h_end & v_end) : ext_vs_rise;

  // position counters
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      h_ff <= 16'h0000;
      v_ff <= 16'h0000;
    end else if (I_CLK_EN) begin
      if (tsel) begin
        // counters run over the configured frame
        if (pix_tick) begin
          h_ff <= h_end ? 16'h0000 : h_ff + 16'h0001;
          if (h_end) begin
            v_ff <= v_end ? 16'h0000 : v_ff + 16'h0001;
          end
        end
      end else begin
        // position follows incoming enable and vsync
        if (ext_vs_rise) begin
          v_ff <= 16'h0000;
          h_ff <= 16'h0000;
        end else if (pix_tick) begin
          if (ext_de) begin
            h_ff <= h_ff + 16'h0001;
          end else if (h_ff != 16'h0000) begin
            h_ff <= 16'h0000;
            v_ff <= v_ff + 16'h0001;
          end
        end
      end
    end
  end

  // next enabled pattern after the current one
  function [3:0] next_pat;
    input [3:0] cur;
    input [15:0] mask;
    integer k;
    reg [3:0] cand;
    reg found;
    begin
      next_pat = cur;
      found = 1'b0;
      cand = cur;
      for (k = 1; k < 16; k = k + 1) begin
        cand = cur + k[3:0];
        if (!found && mask[cand]) begin
          next_pat = cand;
          found = 1'b1;
        end
      end
    end
  endfunction

  // pattern selection and frame time counting
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      frame_ff <= 8'h00;
      pat_ff <= 4'h0;
    end else if (I_CLK_EN) begin
      if (!cfg_ff[`VTP_CFG_AUTO]) begin
        pat_ff <= ctrl_ff[7:4];
        frame_ff <= 8'h00;
      end else if (frame_end) begin
        if (frame_ff + 8'h01 >= ind_ff[`VTP_IND_FTIME]) begin
          frame_ff <= 8'h00;
          pat_ff <= next_pat(pat_ff, pat_mask);
        end else begin
          frame_ff <= frame_ff + 8'h01;
        end
      end
    end
  end

  // cell size one or eight pixels
  wire scale = cfg_ff[`VTP_CFG_SCALE];
  wire chk = scale ? (ax[3] ^ ay[3]) : (ax[0] ^ ay[0]);
  wire [1:0] band = ay[7:6] ^ {2{ctrl_ff[`VTP_CTRL_VREV]}};
  wire [7:0] lvl_h = cfg_ff[`VTP_CFG_RED] ? {ax[5:0], 2'h0} : ax[7:0];
  wire [7:0] lvl_v = cfg_ff[`VTP_CFG_RED] ? {ay[5:0], 2'h0} : ay[7:0];
  wire [23:0] custom = {ind_ff[`VTP_IND_RED], ind_ff[`VTP_IND_GRN], ind_ff[`VTP_IND_BLU]};
  reg [23:0] rgb;
  reg [23:0] base;

  // colour of the current pixel
  always @* begin
    base = 24'h000000;
    rgb = 24'h000000;
    case (pat_ff[3:2] == 2'h1 ? 2'h0 : 2'h0)
      default: base = 24'h000000;
    endcase
    if (ctrl_ff[`VTP_CTRL_BARS]) begin
      rgb = {{8{ax[7]}}, {8{ax[6]}}, {8{ax[5]}}};
    end else begin
      case (pat_ff)
        `VTP_PAT_CHECK: rgb = chk ? (cfg_ff[`VTP_CFG_CUST] ? custom : 24'hFFFFFF) : 24'h000000;
        4'h1: rgb = 24'hFFFFFF;
        4'h2: rgb = 24'h000000;
        4'h3: rgb = 24'hFF0000;
        4'h4: rgb = 24'h00FF00;
        4'h5: rgb = 24'h0000FF;
        4'h6: rgb = {lvl_h, lvl_h, lvl_h};
        4'h7: rgb = {lvl_h, 16'h0000};
        4'h8: rgb = {8'h00, lvl_h, 8'h00};
        4'h9: rgb = {16'h0000, lvl_h};
        4'hA: rgb = {lvl_v, lvl_v, lvl_v};
        4'hB: rgb = {lvl_v, 16'h0000};
        4'hC: rgb = {8'h00, lvl_v, 8'h00};
        4'hD: rgb = {16'h0000, lvl_v};
        `VTP_PAT_CUSTOM: rgb = custom;
        default: begin
          case (band)
            2'h0: base = 24'hFFFF00;
            2'h1: base = 24'h00FFFF;
            2'h2: base = 24'h0000FF;
            default: base = 24'hFF0000;
          endcase
          rgb = chk ? base : 24'h000000;
        end
      endcase
    end
    if (cfg_ff[`VTP_CFG_INV]) begin
      rgb = ~rgb;
    end
    if (cfg_ff[`VTP_CFG_RED]) begin
      rgb = rgb & 24'hFCFCFC;
    end
  end

  // output stage; colour forced to zero outside the active area and while disabled
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N) begin
      r_ff <= 8'h00;
      g_ff <= 8'h00;
      b_ff <= 8'h00;
      de_ff <= 1'b0;
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end else if (I_CLK_EN) begin
      strobe_ff <= pix_tick;
      if (pix_tick) begin
        de_ff <= cur_de;
        hs_ff <= tsel ? ((h_ff < h_sw) ^ ind_ff[`VTP_IND_SYNC][0]) : hs_sync_ff[2];
        vs_ff <= tsel ? ((v_ff < v_sw) ^ ind_ff[`VTP_IND_SYNC][1]) : vs_sync_ff[2];
        if (en & cur_de) begin
          r_ff <= rgb[23:16];
          g_ff <= rgb[15:8];
          b_ff <= rgb[7:0];
        end else begin
          r_ff <= 8'h00;
          g_ff <= 8'h00;
          b_ff <= 8'h00;
        end
      end
    end
  end

  assign O_PIX_STROBE = strobe_ff;
  assign O_PIX_R = r_ff;
  assign O_PIX_G = g_ff;
  assign O_PIX_B = b_ff;
  assign O_PIX_DE = de_ff;
  assign O_PIX_HS = hs_ff;
  assign O_PIX_VS = vs_ff;
  assign O_PATTERN_ACTIVE = en;
endmodule

// *** logic/vtp_regs.vh ***
// register indices, field positions, reset values and timing for the test pattern block
`ifndef VTP_REGS_VH
`define VTP_REGS_VH
`define VTP_IDX_CTRL 8'h64
`define VTP_IDX_CFG 8'h65
`define VTP_IDX_IADDR 8'h66
`define VTP_IDX_IDATA 8'h67
`define VTP_CTRL_RST 8'h10
`define VTP_CFG_RST 8'h00
`define VTP_IADDR_RST 8'h00
`define VTP_CTRL_EN 0
`define VTP_CTRL_VREV 1
`define VTP_CTRL_BARS 2
`define VTP_CTRL_SEL_LO 4
`define VTP_CFG_AUTO 0
`define VTP_CFG_INV 1
`define VTP_CFG_TSEL 2
`define VTP_CFG_EXTCLK 3
`define VTP_CFG_RED 4
`define VTP_CFG_CUST 5
`define VTP_CFG_SCALE 6
`define VTP_IND_RED 5'h00
`define VTP_IND_GRN 5'h01
`define VTP_IND_BLU 5'h02
`define VTP_IND_FTIME 5'h03
`define VTP_IND_HTOT 5'h04
`define VTP_IND_VTOT 5'h06
`define VTP_IND_HACT 5'h08
`define VTP_IND_VACT 5'h0A
`define VTP_IND_HSW 5'h0C
`define VTP_IND_VSW 5'h0D
`define VTP_IND_HBP 5'h0E
`define VTP_IND_VBP 5'h0F
`define VTP_IND_SYNC 5'h10
`define VTP_IND_MASK 5'h11
`define VTP_IND_COUNT 19
`define VTP_PAT_CHECK 4'h0
`define VTP_PAT_CUSTOM 4'hE
`define VTP_PAT_STRIPE 4'hF
`define VTP_DIV_DEFAULT 2
`endif

// *** testbench/vtp_pattern_asserts.sv ***
// concurrent checks on the test pattern block ports
`timescale 1ns/1ps
module vtp_pattern_asserts #(
  parameter DIV = 2
) (
  input wire I_SYS_CLK,
  input wire I_RESET_N,
  input wire [9:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [3:0] I_AVS_BYTEENABLE,
  input wire [31:0] O_AVS_READDATA,
  input wire O_AVS_WAITREQUEST,
  input wire I_EXT_DE,
  input wire O_PIX_STROBE,
  input wire [7:0] O_PIX_R,
  input wire [7:0] O_PIX_G,
  input wire [7:0] O_PIX_B,
  input wire O_PIX_DE,
  input wire O_PIX_HS,
  input wire O_PIX_VS,
  input wire O_PATTERN_ACTIVE
);
  wire req = I_AVS_READ || I_AVS_WRITE;
  wire [23:0] rgb = {O_PIX_R, O_PIX_G, O_PIX_B};
  wire cfg_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == 10'h194;
  reg [7:0] cfg_ff;
  reg [3:0] age_ff;
  wire ok = age_ff == 4'hF;
  // shadow of the configuration byte; video checks that depend on it wait until it has settled
  always @(posedge I_SYS_CLK) begin
    if (!I_RESET_N || cfg_wr) begin
      cfg_ff <= I_RESET_N ? I_AVS_WRITEDATA[7:0] : 8'h00;
      age_ff <= 4'h0;
    end else if (!ok) begin
      age_ff <= age_ff + 4'h1;
    end
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  property p_rd_upper; O_AVS_READDATA[31:8] == 24'h0; endproperty
  property p_idle; !req |-> !O_AVS_WAITREQUEST; endproperty
  property p_one_wait; $rose(req) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST; endproperty
  property p_off_dark;
    O_PIX_STROBE && !$past(O_PATTERN_ACTIVE) && !$past(O_PATTERN_ACTIVE, 2) |-> rgb == 24'h0;
  endproperty
  property p_blank_dark; O_PIX_STROBE && !O_PIX_DE |-> rgb == 24'h0; endproperty
  property p_six_bits;
    ok && cfg_ff[4] && !cfg_ff[1] && O_PIX_STROBE |-> {O_PIX_R[1:0], O_PIX_G[1:0], O_PIX_B[1:0]} == 6'h00;
  endproperty
  property p_ext_de;
    ok && !cfg_ff[2] && O_PATTERN_ACTIVE && O_PIX_STROBE |-> O_PIX_DE == $past(I_EXT_DE, 3);
  endproperty
  property p_int_rate; ok && cfg_ff[2] && !cfg_ff[3] && O_PIX_STROBE |-> ##DIV O_PIX_STROBE; endproperty
  // settle guard: a clock-source switch may put a fresh tick right after an old one
  property p_ext_rate; ok && cfg_ff[3] && O_PIX_STROBE |=> !O_PIX_STROBE [*8]; endproperty
  // syncs lie before the back porch, so with default polarity they are low in the active area
  property p_sync_idle; ok && cfg_ff[2] && O_PIX_STROBE && O_PIX_DE |-> !O_PIX_HS && !O_PIX_VS; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bytes not zero");
  a_idle: assert property (p_idle) else $error("wait request without a request");
  a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait");
  a_off_dark: assert property (p_off_dark) else $error("colour while disabled");
  a_blank_dark: assert property (p_blank_dark) else $error("colour outside active area");
  a_six_bits: assert property (p_six_bits) else $error("low colour bits used in reduced mode");
  a_ext_de: assert property (p_ext_de) else $error("enable does not follow the pixel source");
  a_int_rate: assert property (p_int_rate) else $error("divided pixel rate wrong");
  a_ext_rate: assert property (p_ext_rate) else $error("pixel rate not from pixel clock");
  a_sync_idle: assert property (p_sync_idle) else $error("sync active inside the active area");
  c_own: cover property (ok && cfg_ff[2] && O_PIX_STROBE && O_PIX_DE);
  c_dim: cover property (cfg_ff[4] && O_PIX_STROBE && rgb != 24'h0);
  c_cfg: cover property (age_ff == 4'h0 && cfg_ff != 8'h00);
endmodule
bind vtp_pattern_gen vtp_pattern_asserts #(.DIV(DIV)) u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_EXT_DE(I_EXT_DE), .O_PIX_STROBE(O_PIX_STROBE), .O_PIX_R(O_PIX_R),
  .O_PIX_G(O_PIX_G), .O_PIX_B(O_PIX_B), .O_PIX_DE(O_PIX_DE), .O_PIX_HS(O_PIX_HS), .O_PIX_VS(O_PIX_VS),
  .O_PATTERN_ACTIVE(O_PATTERN_ACTIVE));

// *** testbench/vtp_pix_src.sv ***
// external pixel source: slow pixel clock, data enable and syncs
`timescale 1ns/1ps
module vtp_pix_src (
  input wire i_clk,
  output reg o_pclk,
  output wire o_de,
  output wire o_hs,
  output wire o_vs
);
  reg [3:0] div_ff = 4'h0;
  reg [5:0] col_ff = 6'h00;
  reg [4:0] row_ff = 5'h00;
  initial o_pclk = 1'b0;
  // lines move on the falling pixel clock, so they sit still around each rise
  always @(posedge i_clk) begin
    div_ff <= (div_ff == 4'h4) ? 4'h0 : div_ff + 4'h1;
    if (div_ff == 4'h4) begin
      o_pclk <= ~o_pclk;
      if (o_pclk) begin
        col_ff <= (col_ff == 6'h27) ? 6'h00 : col_ff + 6'h01;
        row_ff <= row_ff + {4'h0, col_ff == 6'h27};
      end
    end
  end
  // 32 visible pixels of 40, one sync pulse per line and per frame
  assign o_de = col_ff < 6'h20;
  assign o_hs = col_ff[5:1] == 5'h11;
  assign o_vs = row_ff == 5'h00;
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the test pattern block
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [9:0] addr = 10'h000;
  reg [31:0] wdat = 32'h0;
  reg [31:0] q;
  wire [31:0] rdat;
  wire [7:0] r, g, b;
  wire wreq, stb, de, pclk, xde, xhs, xvs, act;
  integer n_errors = 0;
  integer compares = 0;
  integer n;
  integer k;
  // system clock
  always #12.5 clk = ~clk;
  vtp_pix_src u_src (.i_clk(clk), .o_pclk(pclk), .o_de(xde), .o_hs(xhs), .o_vs(xvs));
  vtp_pattern_gen #(.DIV(2)) u_dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CLK_EN(1'b1), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .I_EXT_PCLK(pclk), .I_EXT_DE(xde), .I_EXT_HS(xhs), .I_EXT_VS(xvs),
    .O_PIX_STROBE(stb), .O_PIX_R(r), .O_PIX_G(g), .O_PIX_B(b), .O_PIX_DE(de), .O_PIX_HS(), .O_PIX_VS(),
    .O_PATTERN_ACTIVE(act));
  // one bus access; the request stands until wait request is seen low
  task bus(input w, input [9:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdat <= {24'h0, d};
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task chk(input [95:0] what, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task rdchk(input [95:0] what, input [9:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 8'h00);
      chk(what, exp, q);
    end
  endtask
  task wr8(input [9:0] a, input [7:0] d);
    bus(1'b1, a, d);
  endtask
  // indirect write; address always goes first
  task iwr(input [7:0] ia, input [7:0] d);
    begin
      wr8(10'h198, ia);
      wr8(10'h19C, d);
    end
  endtask
  // program a pattern, skip to a blank strobe, then judge 32 visible pixels
  task pat(input [7:0] ctl, input [7:0] cf, input [23:0] col, input [1:0] mode);
    integer bad, fl, t;
    reg [23:0] px, pv;
    begin
      wr8(10'h194, cf);
      wr8(10'h190, ctl);
      bad = 0;
      fl = 0;
      k = -1;
      t = 0;
      pv = 24'h0;
      while (k < 32 && t < 30000) begin
        @(posedge clk);
        t = t + 1;
        if (stb === 1'b1 && de !== 1'b1 && k < 0) begin
          k = 0;
        end else if (stb === 1'b1 && de === 1'b1 && k >= 0) begin
          px = {r, g, b};
          if (px !== col && px !== 24'h0) bad = bad + 1;
          if (k > 0 && px !== pv) fl = fl + 1;
          pv = px;
          k = k + 1;
        end
      end
      chk("pixels", 32'd32, k + 64 * bad);
      chk("changes", 32'd1, (mode == 2'd0) ? fl == 0 : (mode == 2'd1) ? fl >= 16 : fl <= 5);
    end
  endtask
  // count one line of visible strobes under the block's own timing
  task own(input [7:0] cf);
    integer t;
    begin
      wr8(10'h194, cf);
      k = -1;
      t = 0;
      n = 0;
      while (n == 0 && t < 40000) begin
        @(posedge clk);
        t = t + 1;
        if (stb === 1'b1) begin
          if (de !== 1'b1 && k > 0) n = k;
          else if (de !== 1'b1) k = 0;
          else if (k >= 0) k = k + 1;
        end
      end
      chk("line", 32'd16, n);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk("active", 32'd0, {31'd0, act});
    rdchk("control", 10'h190, 32'h10);
    rdchk("config", 10'h194, 32'h00);
    rdchk("iaddr", 10'h198, 32'h00);
    rdchk("idata", 10'h19C, 32'hFF);
    rdchk("unmapped", 10'h3FC, 32'h00);
    wr8(10'h194, 8'hFF);
    rdchk("config", 10'h194, 32'h7F);
    iwr(8'h11, 8'h55);
    rdchk("iaddr", 10'h198, 32'h11);
    rdchk("idata", 10'h19C, 32'h55);
    wr8(10'h198, 8'h03);
    rdchk("idata", 10'h19C, 32'h3C);
    iwr(8'h20, 8'h77);
    rdchk("idata", 10'h19C, 32'h00);
    iwr(8'h00, 8'hA5);
    iwr(8'h01, 8'h3C);
    iwr(8'h02, 8'h96);
    pat(8'h01, 8'h20, 24'hA53C96, 2'd1);
    chk("active", 32'd1, {31'd0, act});
    pat(8'h01, 8'h60, 24'hA53C96, 2'd2);
    pat(8'h01, 8'h00, 24'hFFFFFF, 2'd1);
    pat(8'hE1, 8'h00, 24'hA53C96, 2'd0);
    pat(8'hE1, 8'h02, 24'h5AC369, 2'd0);
    pat(8'hE1, 8'h18, 24'hA43C94, 2'd0);
    iwr(8'h04, 8'h28);
    iwr(8'h05, 8'h00);
    iwr(8'h08, 8'h10);
    iwr(8'h09, 8'h00);
    iwr(8'h0C, 8'h04);
    iwr(8'h0E, 8'h04);
    own(8'h04);
    own(8'h0C);
    tally_and_finish;
  end
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk);
    n_errors = n_errors + 1;
    tally_and_finish;
  end
endmodule
